/* dma_channel_control.sv */
// dma channel control: register slave, handshake, packet sequencing
//
// Notes on behaviour
// - handshake disable set: flow control requests are all ignored
// - lock bit holds the arbiter on this channel until transfer ends or a packet ends with no start condition pending
// - device step bit adds packet size to device pointer per packet
// - memory step bit adds packet size to memory pointer per packet
// - memory stepping off: transfer ends only by terminate or abort
// - select field picks which flow bus index serves this channel
// - direction one reads memory, writes device; zero the reverse
// - busy reads one whenever the state machine is not idle
// - done reads not busy and run, zero when channel off
// - request bit shows the selected master presenting a request
// - in hardware flow mode requests served only while run set
// - go bit starts firmware-driven transfer with handshake disabled
// - abort bit ends the current transfer at once
// - pointer reaching end flags done; terminate does not flag done
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module dma_channel_control
  import dma_chan_pkg::*;
#(
  parameter int NREQ = 128
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NREQ-1:0] flow_req,
  input wire logic [NREQ-1:0] flow_term,
  output logic arb_req,
  input wire logic arb_grant,
  output logic arb_lock,
  output logic pkt_valid,
  output logic [31:0] pkt_rd_addr,
  output logic [31:0] pkt_wr_addr,
  output logic [2:0] pkt_size,
  input wire logic pkt_ack,
  input wire logic pkt_err,
  output logic irq
);
  chan_state_type st_q;
  logic [31:0] ctl_q, mem_ptr_q, mem_end_q, dev_ptr_q;
  logic [2:0] stat_q, mask_q;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic complete_q, term_pend_q;
  logic req_sel, term_sel;
  logic wr_go, rd_go, wr_hit_ok, rd_hit_ok;
  logic hw_en, start_hw, start_fw, ovfl_evt, done_evt, ended;
  logic [31:0] step, mem_next, dev_next, ctl_rd, rd_val;

  // merge byte lanes of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // known register offsets
  function automatic logic mapped(input logic [7:0] a);
    return (a == MEM_PTR_OFF) || (a == MEM_END_OFF) || (a == DEV_PTR_OFF)
      || (a == CTL_OFF) || (a == STAT_OFF) || (a == MASK_OFF);
  endfunction

  // pointer value after this packet's step
  function automatic logic [31:0] mem_next_sel(input logic m);
    return (m && ctl_q[CTL_MEM_INC]) ? mem_next : mem_ptr_q;
  endfunction
  function automatic logic [31:0] dev_next_sel(input logic m);
    return (!m && ctl_q[CTL_DEV_INC]) ? dev_next : dev_ptr_q;
  endfunction

  flow_select #(
    .NREQ(NREQ),
    .SELW(CTL_SEL_HI - CTL_SEL_LO + 1)
  ) u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .req_bus(flow_req),
    .term_bus(flow_term),
    .sel(ctl_q[CTL_SEL_HI:CTL_SEL_LO]),
    .req_q(req_sel),
    .term_q(term_sel)
  );

  // write channel and read channel handshakes
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit_ok = mapped(aw_addr_q);
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_hit_ok = mapped(s_axi_araddr);

  // start and end conditions
  // handshake disable masks requests
  assign hw_en = ctl_q[CTL_RUN] && !ctl_q[CTL_HW_DIS];
  assign start_hw = hw_en && req_sel && !term_sel && !complete_q;
  assign start_fw = ctl_q[CTL_HW_DIS] && ctl_q[CTL_GO] && !complete_q;
  assign ovfl_evt = hw_en && req_sel && complete_q && (st_q == ST_IDLE);
  // size field used as byte count
  assign step = {29'h0, ctl_q[CTL_SIZE_HI:CTL_SIZE_LO]};
  assign mem_next = mem_ptr_q + step;
  assign dev_next = dev_ptr_q + step;
  // only memory stepping reaches the end
  // end compare after each packet
  // a terminate seen during the packet wins over reaching the limit
  assign done_evt = (st_q == ST_MOVE) && pkt_ack && ctl_q[CTL_MEM_INC]
    && (mem_next == mem_end_q) && !ctl_q[CTL_ABORT] && !term_pend_q
    && !(term_sel && !ctl_q[CTL_HW_DIS]);
  // terminate counts only with handshake enabled
  assign ended = done_evt || term_pend_q || (term_sel && !ctl_q[CTL_HW_DIS]);

  always_comb
  begin
    ctl_rd = ctl_q & CTL_WMASK;
    ctl_rd[CTL_BUSY] = (st_q != ST_IDLE);
    ctl_rd[CTL_DONE] = (st_q == ST_IDLE) && ctl_q[CTL_RUN];
    ctl_rd[CTL_REQ] = req_sel;
  end

  // read data selection
  always_comb
  begin
    case (s_axi_araddr)
      MEM_PTR_OFF: rd_val = mem_ptr_q;
      MEM_END_OFF: rd_val = mem_end_q;
      DEV_PTR_OFF: rd_val = dev_ptr_q;
      CTL_OFF: rd_val = ctl_rd;
      STAT_OFF: rd_val = {29'h0, stat_q};
      MASK_OFF: rd_val = {29'h0, mask_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_have_q <= 1'b0;
      end
    end
  end

  // bus handshake outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control register; go drops when the transfer ends, except when abort ends it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= CTL_RESET;
    end
    else
    begin
      if (wr_go && aw_addr_q == CTL_OFF)
      begin
        // writes land only on writable bits
        ctl_q <= merge(ctl_q, w_data_q, w_strb_q) & CTL_WMASK;
      end
      else if (ended && st_q != ST_IDLE)
      begin
        ctl_q[CTL_GO] <= 1'b0;
      end
    end
  end

  // pointers and limit; software writes win over stepping
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_ptr_q <= PTR_RESET;
      mem_end_q <= PTR_RESET;
      dev_ptr_q <= PTR_RESET;
    end
    else
    begin
      if (wr_go && aw_addr_q == MEM_PTR_OFF)
      begin
        mem_ptr_q <= merge(mem_ptr_q, w_data_q, w_strb_q);
      end
      else if (st_q == ST_MOVE && pkt_ack && ctl_q[CTL_MEM_INC])
      begin
        mem_ptr_q <= mem_next;
      end
      if (wr_go && aw_addr_q == MEM_END_OFF)
      begin
        mem_end_q <= merge(mem_end_q, w_data_q, w_strb_q);
      end
      if (wr_go && aw_addr_q == DEV_PTR_OFF)
      begin
        dev_ptr_q <= merge(dev_ptr_q, w_data_q, w_strb_q);
      end
      else if (st_q == ST_MOVE && pkt_ack && ctl_q[CTL_DEV_INC])
      begin
        dev_ptr_q <= dev_next;
      end
    end
  end

  // completion memory; a new memory pointer or memory end rearms the channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      complete_q <= 1'b0;
    end
    else if (done_evt)
    begin
      complete_q <= 1'b1;
    end
    else if (wr_go && (aw_addr_q == MEM_PTR_OFF || aw_addr_q == MEM_END_OFF))
    begin
      complete_q <= 1'b0;
    end
  end

  // channel state machine and packet issue
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      arb_req <= 1'b0;
      arb_lock <= 1'b0;
      pkt_valid <= 1'b0;
      pkt_rd_addr <= 32'h0000_0000;
      pkt_wr_addr <= 32'h0000_0000;
      pkt_size <= 3'h0;
      term_pend_q <= 1'b0;
    end
    else if (ctl_q[CTL_ABORT])
    begin
      st_q <= ST_IDLE;
      arb_req <= 1'b0;
      arb_lock <= 1'b0;
      pkt_valid <= 1'b0;
      term_pend_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          term_pend_q <= 1'b0;
          if (start_hw || start_fw)
          begin
            st_q <= ST_ARB;
            arb_req <= 1'b1;
          end
        end
        ST_ARB:
        begin
          if (term_sel && !ctl_q[CTL_HW_DIS])
          begin
            st_q <= ST_IDLE;
            arb_req <= 1'b0;
            arb_lock <= 1'b0;
          end
          else if (arb_grant)
          begin
            st_q <= ST_MOVE;
            arb_lock <= ctl_q[CTL_LOCK];
            arb_req <= ctl_q[CTL_LOCK];
            pkt_valid <= 1'b1;
            pkt_size <= ctl_q[CTL_SIZE_HI:CTL_SIZE_LO];
            pkt_rd_addr <= ctl_q[CTL_DIR] ? mem_ptr_q : dev_ptr_q;
            pkt_wr_addr <= ctl_q[CTL_DIR] ? dev_ptr_q : mem_ptr_q;
          end
        end
        ST_MOVE:
        begin
          if (term_sel && !ctl_q[CTL_HW_DIS])
          begin
            term_pend_q <= 1'b1;
          end
          if (pkt_ack)
          begin
            pkt_valid <= 1'b0;
            if (done_evt || term_pend_q || (term_sel && !ctl_q[CTL_HW_DIS]))
            begin
              st_q <= ST_IDLE;
              arb_req <= 1'b0;
              arb_lock <= 1'b0;
            end
            else if (ctl_q[CTL_LOCK] && (start_fw || start_hw))
            begin
              // locked: next packet keeps the grant
              st_q <= ST_MOVE;
              pkt_valid <= 1'b1;
              pkt_rd_addr <= ctl_q[CTL_DIR] ? mem_next_sel(1'b1) : dev_next_sel(1'b0);
              pkt_wr_addr <= ctl_q[CTL_DIR] ? dev_next_sel(1'b0) : mem_next_sel(1'b1);
            end
            else if (start_fw)
            begin
              st_q <= ST_ARB;
              arb_req <= 1'b1;
              arb_lock <= 1'b0;
            end
            else
            begin
              st_q <= ST_IDLE;
              arb_req <= 1'b0;
              arb_lock <= 1'b0;
            end
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
          arb_req <= 1'b0;
          arb_lock <= 1'b0;
          pkt_valid <= 1'b0;
        end
      endcase
    end
  end

  // sticky status, read of status clears, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= STAT_RESET;
      mask_q <= STAT_RESET;
    end
    else
    begin
      if (rd_go && s_axi_araddr == STAT_OFF)
      begin
        stat_q <= 3'h0;
      end
      if (done_evt)
      begin
        stat_q[ST_DONE] <= 1'b1;
      end
      if (ovfl_evt)
      begin
        stat_q[ST_OVFL] <= 1'b1;
      end
      if (st_q == ST_MOVE && pkt_ack && pkt_err)
      begin
        stat_q[ST_BERR] <= 1'b1;
      end
      if (wr_go && aw_addr_q == MASK_OFF && w_strb_q[0])
      begin
        mask_q <= w_data_q[2:0];
      end
    end
  end

  // interrupt level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(stat_q & mask_q);
    end
  end

  // checks
  sequence s_grant;
    st_q == ST_ARB && arb_grant && !ctl_q[CTL_ABORT] && !term_sel;
  endsequence
  sequence s_ctl_read;
    rd_go && s_axi_araddr == CTL_OFF;
  endsequence

  property p_hw_ignored;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == ST_IDLE && ctl_q[CTL_HW_DIS] && !ctl_q[CTL_GO]) |=> st_q == ST_IDLE;
  endproperty
  a_hw_ignored: assert property (p_hw_ignored) else $error("start with handshake off");

  property p_run_gate;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == ST_IDLE && !ctl_q[CTL_RUN] && !ctl_q[CTL_HW_DIS]) |=> st_q == ST_IDLE;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("start while run is off");

  property p_lock;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == ST_MOVE && ctl_q[CTL_LOCK] && $past(st_q) == ST_ARB) |-> arb_lock && arb_req;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not held");

  property p_dir;
    @(posedge aclk) disable iff (!aresetn)
      s_grant |=> pkt_valid && pkt_rd_addr == ($past(ctl_q[CTL_DIR]) ?
        $past(mem_ptr_q) : $past(dev_ptr_q));
  endproperty
  a_dir: assert property (p_dir) else $error("packet source wrong");

  property p_mem_step;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == ST_MOVE && pkt_ack && ctl_q[CTL_MEM_INC] && !wr_go)
        |=> mem_ptr_q == $past(mem_ptr_q) + $past(step);
  endproperty
  a_mem_step: assert property (p_mem_step) else $error("memory step wrong");

  property p_dev_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!ctl_q[CTL_DEV_INC] && !wr_go) |=> dev_ptr_q == $past(dev_ptr_q);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device pointer moved");

  property p_done_flag;
    @(posedge aclk) disable iff (!aresetn)
      $rose(stat_q[ST_DONE]) |-> $past(ctl_q[CTL_MEM_INC]) && $past(st_q) == ST_MOVE;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done without limit");

  property p_busy;
    @(posedge aclk) disable iff (!aresetn)
      s_ctl_read |=> s_axi_rdata[CTL_BUSY] == ($past(st_q) != ST_IDLE)
        && s_axi_rdata[CTL_DONE] == ($past(st_q) == ST_IDLE && $past(ctl_q[CTL_RUN]));
  endproperty
  a_busy: assert property (p_busy) else $error("busy or done read wrong");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
      ctl_q[CTL_ABORT] |=> st_q == ST_IDLE && !pkt_valid && !arb_lock;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not end transfer");
endmodule

/* dma_chan_pkg.sv */
// shared offsets, fields and codes for the dma channel block
package dma_chan_pkg;
  // register byte offsets
  localparam logic [7:0] MEM_PTR_OFF = 8'h04;
  localparam logic [7:0] MEM_END_OFF = 8'h08;
  localparam logic [7:0] DEV_PTR_OFF = 8'h0C;
  localparam logic [7:0] CTL_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] MASK_OFF = 8'h18;
  // control field positions
  localparam int CTL_ABORT = 25;
  localparam int CTL_GO = 24;
  localparam int CTL_SIZE_HI = 22;
  localparam int CTL_SIZE_LO = 20;
  localparam int CTL_HW_DIS = 19;
  localparam int CTL_LOCK = 18;
  localparam int CTL_DEV_INC = 17;
  localparam int CTL_MEM_INC = 16;
  localparam int CTL_SEL_HI = 15;
  localparam int CTL_SEL_LO = 9;
  localparam int CTL_DIR = 8;
  localparam int CTL_BUSY = 5;
  localparam int CTL_DONE = 2;
  localparam int CTL_REQ = 1;
  localparam int CTL_RUN = 0;
  // writable control bits; reserved bits stay zero except bit 23, which is writable
  localparam logic [31:0] CTL_WMASK = 32'h03FF_FF01;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  // status and mask bit positions
  localparam int ST_DONE = 2;
  localparam int ST_OVFL = 1;
  localparam int ST_BERR = 0;
  localparam logic [2:0] STAT_RESET = 3'h0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // channel state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARB = 3'b010,
    ST_MOVE = 3'b100
  } chan_state_type;
endpackage

/* flow_select.sv */
// picks one master's request and terminate lines off the flow bus
`timescale 1ns/1ps
module flow_select
  import dma_chan_pkg::*;
#(
  parameter int NREQ = 128,
  parameter int SELW = 7
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NREQ-1:0] req_bus,
  input wire logic [NREQ-1:0] term_bus,
  input wire logic [SELW-1:0] sel,
  output logic req_q,
  output logic term_q
);
  // index out of range reads as no request
  function automatic logic pick(input logic [NREQ-1:0] bus,
                                input logic [SELW-1:0] idx);
    logic r;
    r = 1'b0;
    if (int'(idx) < NREQ)
    begin
      r = bus[idx];
    end
    return r;
  endfunction

  // registered selection of the handshake master
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_q <= 1'b0;
      term_q <= 1'b0;
    end
    else
    begin
      req_q <= pick(req_bus, sel);
      term_q <= pick(term_bus, sel);
    end
  end
endmodule

/* flow_master_model.sv */
// peripheral master model: flow request lines and packet completion
`timescale 1ns/1ps
module flow_master_model
#(
  parameter int NREQ = 128
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] req_idx,
  input wire logic req_on,
  input wire logic term_on,
  input wire logic err_on,
  input wire logic [7:0] ack_wait,
  input wire logic pkt_valid,
  output logic [NREQ-1:0] flow_req,
  output logic [NREQ-1:0] flow_term,
  output logic pkt_ack,
  output logic pkt_err
);
  logic [7:0] wait_q;
  logic fire;

  // acknowledge once the programmed delay has run out
  assign fire = pkt_valid && !pkt_ack && (wait_q == ack_wait);

  // this master drives only its own index of the concatenated bus
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flow_req <= '0;
      flow_term <= '0;
    end
    else
    begin
      flow_req <= req_on ? (NREQ'(1) << req_idx) : '0;
      flow_term <= term_on ? (NREQ'(1) << req_idx) : '0;
    end
  end

  // one-cycle ack; error line is meaningless and toggles outside it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pkt_ack <= 1'h0;
      pkt_err <= 1'h0;
      wait_q <= 8'h00;
    end
    else
    begin
      pkt_ack <= fire;
      pkt_err <= fire ? err_on : ~pkt_err;
      wait_q <= (pkt_valid && !pkt_ack && !fire) ? wait_q + 8'h01 : 8'h00;
    end
  end
endmodule

/* tb_top.sv */
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
module tb_top;
  import dma_chan_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val, seed, mem, dev, ctl;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  logic [127:0] flow_req, flow_term;
  logic arb_req, arb_grant, arb_lock, pkt_valid, pkt_ack, pkt_err, irq;
  logic [31:0] pkt_rd_addr, pkt_wr_addr;
  logic [2:0] pkt_size, sz;
  logic [6:0] req_idx, sel;
  logic req_on, term_on, err_on, lk, di, mi, dir;
  logic [7:0] ack_wait;
  logic [2:0] sizes [3] = '{3'h1, 3'h2, 3'h4};
  logic [7:0] offs [4] = '{CTL_OFF, STAT_OFF, MASK_OFF, MEM_PTR_OFF};
  int err_total, compares, cyc, ack_n, hits;

  dma_channel_control dma_channel_control_i (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flow_req, .flow_term, .arb_req, .arb_grant, .arb_lock, .pkt_valid, .pkt_rd_addr,
    .pkt_wr_addr, .pkt_size, .pkt_ack, .pkt_err, .irq);

  flow_master_model flow_master_model_i (.aclk, .aresetn, .req_idx, .req_on, .term_on,
    .err_on, .ack_wait, .pkt_valid, .flow_req, .flow_term, .pkt_ack, .pkt_err);

  // free-running system clock
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // arbiter stand-in grants one cycle after the ask; watchdog and ack count
  always @(posedge aclk)
  begin
    arb_grant <= arb_req;
    cyc++;
    if (pkt_ack === 1'h1)
      ack_n++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic [31:0] ctl_word(input logic abt, go, input logic [2:0] s,
    input logic dis, lock, dinc, minc, input logic [6:0] idx, input logic d, run);
    return {6'h0, abt, go, 1'h0, s, dis, lock, dinc, minc, idx, d, 7'h0, run};
  endfunction

  function automatic logic [31:0] step(input logic [31:0] b, input logic en,
    input logic [2:0] s);
    return en ? b + {29'h0, s} : b;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'h0;
  endtask

  // read: data and response captured at the edge rvalid is seen
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'h0;
  endtask

  // main sequence
  initial
  begin
    seed = 32'h9E74F320;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, req_on, term_on, err_on} = '0;
    {awaddr, araddr, wdata, req_idx, ack_wait} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    // reset values, reserved bits, unmapped offset
    foreach (offs[j])
    begin
      rd(offs[j]);
      chk("reset value", 32'h0, rd_val);
    end
    wr(CTL_OFF, 32'hFC0000FE);
    rd(CTL_OFF);
    chk("reserved bits", 32'h0, rd_val);
    rd(8'h40);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rd_resp));
    // hardware flow control packets with random setup
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      mem = {16'h2000, seed[15:4], 4'h0};
      dev = {16'h4000, seed[31:20], 4'h0};
      {sel, lk, di, mi, dir, sz} = {seed[22:16], seed[10:8], i[0], sizes[i % 3]};
      ctl = ctl_word(1'h0, 1'h0, sz, 1'h0, lk, di, mi, sel, dir, 1'h1);
      wr(MEM_PTR_OFF, mem);
      wr(MEM_END_OFF, mem + 32'h100);
      wr(DEV_PTR_OFF, dev);
      wr(CTL_OFF, ctl);
      req_idx <= sel;
      req_on <= 1'h1;
      ack_wait <= 8'h1E;
      while (pkt_valid !== 1'h1)
        @(posedge aclk);
      chk("read address", dir ? mem : dev, pkt_rd_addr);
      chk("write address", dir ? dev : mem, pkt_wr_addr);
      chk("packet size", 32'(sz), 32'(pkt_size));
      chk("lock", 32'(lk), 32'(arb_lock));
      rd(CTL_OFF);
      chk("busy", 32'h1, 32'(rd_val[CTL_BUSY]));
      chk("request", 32'h1, 32'(rd_val[CTL_REQ]));
      req_on <= 1'h0;
      while (pkt_ack !== 1'h1)
        @(posedge aclk);
      repeat (3) @(posedge aclk);
      rd(MEM_PTR_OFF);
      chk("memory pointer", step(mem, mi, sz), rd_val);
      rd(DEV_PTR_OFF);
      chk("device pointer", step(dev, di, sz), rd_val);
      rd(CTL_OFF);
      chk("control idle", ctl | 32'h4, rd_val);
      chk("lock idle", 32'h0, 32'(arb_lock));
    end
    // requests ignored: handshake off, run off, other index
    for (int k = 0; k < 3; k++)
    begin
      wr(CTL_OFF, ctl_word(1'h0, 1'h0, 3'h1, k == 0, 1'h0, 1'h0, 1'h1, 7'h05, 1'h0, k != 1));
      req_idx <= (k == 2) ? 7'h06 : 7'h05;
      req_on <= 1'h1;
      hits = 0;
      repeat (20)
      begin
        @(posedge aclk);
        if ((arb_req | pkt_valid) !== 1'h0)
          hits++;
      end
      rd(CTL_OFF);
      req_on <= 1'h0;
      chk("ignored request", 32'h0, 32'(hits));
      chk("idle busy", 32'h0, 32'(rd_val[CTL_BUSY]));
      chk("idle done", 32'(k != 1), 32'(rd_val[CTL_DONE]));
      if (k == 2)
        chk("other request", 32'h0, 32'(rd_val[CTL_REQ]));
    end
    // firmware transfer to the end address, done interrupt
    wr(MASK_OFF, 32'h7);
    mem = {16'h0000, seed[15:4], 4'h0};
    wr(MEM_PTR_OFF, mem);
    wr(MEM_END_OFF, mem + 32'hC);
    ack_wait <= 8'h00;
    ack_n = 0;
    ctl = ctl_word(1'h0, 1'h0, 3'h4, 1'h1, 1'h0, 1'h0, 1'h1, 7'h00, 1'h1, 1'h1);
    wr(CTL_OFF, ctl | 32'h01000000);
    while (irq !== 1'h1)
      @(posedge aclk);
    chk("packets", 32'h3, 32'(ack_n));
    rd(STAT_OFF);
    chk("status done", 32'h4, rd_val);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, 32'(irq));
    rd(MEM_PTR_OFF);
    chk("end pointer", mem + 32'hC, rd_val);
    rd(CTL_OFF);
    chk("control done", ctl | 32'h4, rd_val);
    // hardware request after completion: overflow status, no restart
    wr(CTL_OFF, ctl_word(1'h0, 1'h0, 3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 7'h09, 1'h0, 1'h1));
    req_idx <= 7'h09;
    req_on <= 1'h1;
    repeat (8) @(posedge aclk);
    req_on <= 1'h0;
    repeat (3) @(posedge aclk);
    rd(STAT_OFF);
    chk("overflow status", 32'h2, rd_val);
    chk("no restart", 32'h0, 32'(arb_req));
    // endless transfer without memory stepping, masked error, abort
    wr(MASK_OFF, 32'h0);
    err_on <= 1'h1;
    ack_wait <= 8'h02;
    wr(MEM_PTR_OFF, mem);
    ctl = ctl_word(1'h0, 1'h0, 3'h1, 1'h1, 1'h0, 1'h0, 1'h0, 7'h00, 1'h0, 1'h1);
    wr(CTL_OFF, ctl | 32'h01000000);
    repeat (40) @(posedge aclk);
    rd(CTL_OFF);
    chk("endless busy", 32'h1, 32'(rd_val[CTL_BUSY]));
    chk("masked irq", 32'h0, 32'(irq));
    wr(MASK_OFF, 32'h1);
    repeat (3) @(posedge aclk);
    chk("unmasked irq", 32'h1, 32'(irq));
    wr(CTL_OFF, ctl | 32'h02000000);
    err_on <= 1'h0;
    rd(CTL_OFF);
    chk("aborted busy", 32'h0, 32'(rd_val[CTL_BUSY]));
    rd(STAT_OFF);
    chk("bus error status", 32'h1, rd_val);
    wr(CTL_OFF, 32'h0);
    // terminate during the last packet gives no done flag
    wr(MEM_PTR_OFF, mem);
    wr(MEM_END_OFF, mem + 32'h2);
    wr(CTL_OFF, ctl_word(1'h0, 1'h0, 3'h2, 1'h0, 1'h0, 1'h0, 1'h1, 7'h03, 1'h0, 1'h1));
    req_idx <= 7'h03;
    req_on <= 1'h1;
    ack_wait <= 8'h05;
    while (pkt_valid !== 1'h1)
      @(posedge aclk);
    req_on <= 1'h0;
    term_on <= 1'h1;
    while (pkt_ack !== 1'h1)
      @(posedge aclk);
    repeat (4) @(posedge aclk);
    term_on <= 1'h0;
    rd(STAT_OFF);
    chk("terminate status", 32'h0, rd_val);
    test_done();
  end
endmodule
